// ==== omc_map.svh ====
// What this block does
// - Mode pin high at reset release: run mode, fetch vector at 0xFFFE.
// - Mode pin low at reset release: enter active background mode.
// - Halt command, background instruction or either breakpoint enters background.
// - In background mode the CPU is suspended and fetches nothing.
// - Non-intrusive commands accepted in run and background modes.
// - CPU register, trace and resume commands only in background mode.
// - WAIT gates the CPU clock; system clocks and regulation stay on.
// - Entering wait clears the interrupt mask bit.
// - Interrupt ends wait; CPU resumes with interrupt stacking.
// - In wait only halt and status commands; status returns stop/wait error.
// - Halt command during wait wakes into background mode.
// - STOP enters stop only with stop enable set; clocks halt unless kept.
// - STOP with stop enable clear causes illegal opcode reset.
// - Debug enable set: STOP enters stop3 with debug logic kept on.
// - Both low-voltage enables set: stop3 with regulator active.
// - Stop3 keeps registers, RAM and pin levels.
// - Stop3 exits on reset pin or any listed wake interrupt source.
// - Reset pin exit fetches reset vector; interrupt exit its own vector.
// - Debug enable lives in debug status register, debug-only write; the status word shows it.
// - Debug enable at STOP keeps debug clocks and full regulation.
// - Stop refuses most commands; halt wakes to background if debug enabled.
`ifndef OMC_MAP_SVH
`define OMC_MAP_SVH
`define OMC_RESET_VECTOR 16'hfffe
`define OMC_ADDR_CTRL 32'h0000_0000
`define OMC_ADDR_STATUS 32'h0000_0004
`define OMC_ADDR_DBGSC 32'h0000_0008
`define OMC_CTRL_RESET 32'h0000_0000
`define OMC_CTRL_STOP_EN 0
`define OMC_CTRL_LV_DET 1
`define OMC_CTRL_LV_STOP 2
`define OMC_CTRL_PART_PD 3
`define OMC_CTRL_REFKEEP 4
`define OMC_DSC_DEBUG_EN 0
`define OMC_WAKE_W 8
`endif

// ==== omc_pkg.sv ====
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_RUN, OMC_BKG, OMC_WAIT, OMC_STOP3, OMC_STOP2
  } omc_mode_t;
  typedef enum logic [3:0] {
    OMC_CMD_MEM, OMC_CMD_MEMSTAT, OMC_CMD_DBGREG, OMC_CMD_HALT,
    OMC_CMD_CPUREG, OMC_CMD_TRACE, OMC_CMD_GO, OMC_CMD_NONE
  } omc_cmd_t;
endpackage : omc_pkg

// ==== omc_top.sv ====
// Decided for this implementation: the address map and the AHB-Lite register port.
`include "omc_map.svh"
module omc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic mode_select_pin,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_dbg_write,
  input wire logic [31:0] cmd_wdata,
  input wire logic bkg_instr,
  input wire logic debug_ctl_breakpoint,
  input wire logic dbg_breakpoint,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic irq_request,
  input wire logic reset_pin_n,
  input wire logic [7:0] wake_src,
  output logic cmd_accept,
  output logic cmd_refuse,
  output logic cmd_stopwait_err,
  output logic [31:0] cmd_rdata,
  output logic cpu_clk_en,
  output logic cpu_fetch_en,
  output logic sys_clk_en,
  output logic debug_clk_en,
  output logic regulator_full,
  output logic state_hold,
  output logic int_mask_clear,
  output logic illegal_op_reset,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic int_vector_fetch,
  output logic [2:0] mode
);
  omc_pkg::omc_mode_t state;
  omc_pkg::omc_mode_t next_state;
  logic [1:0] ms_sync;
  logic [1:0] rst_sync;
  logic [7:0] wake_s1;
  logic [7:0] wake_s2;
  logic boot_pending;
  logic [31:0] ctrl;
  logic debug_enable;
  logic in_stop;
  logic dbg_reg_hit;
  logic ph_valid;
  logic ph_write;
  logic [31:0] ph_addr;
  logic cmd_ok;
  logic halt_cmd;
  logic go_cmd;
  logic stop_ok;
  logic wake_any;

  // The mode pin synchroniser runs through reset, so its level is settled
  // when the boot sample is taken at the first edge after release.
  always_ff @(posedge hclk) begin
    ms_sync <= {ms_sync[0], mode_select_pin};
  end

  // The reset pin and wake source inputs pass two flip-flops before use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_sync <= 2'h3;
      wake_s1 <= 8'h00;
      wake_s2 <= 8'h00;
    end else begin
      rst_sync <= {rst_sync[0], reset_pin_n};
      wake_s1 <= wake_src;
      wake_s2 <= wake_s1;
    end
  end

  assign halt_cmd = cmd_valid &&
    (omc_pkg::omc_cmd_t'(cmd_code) == omc_pkg::OMC_CMD_HALT);
  assign go_cmd = cmd_valid &&
    (omc_pkg::omc_cmd_t'(cmd_code) == omc_pkg::OMC_CMD_GO);
  assign wake_any = (|wake_s2) || irq_request;
  assign stop_ok = ctrl[`OMC_CTRL_STOP_EN];

  // Both stop modes share the clock and regulator decisions below.
  assign in_stop = (state == omc_pkg::OMC_STOP3) ||
                   (state == omc_pkg::OMC_STOP2);

  // An accepted debug register command reads or writes the debug enable.
  assign dbg_reg_hit = cmd_valid && cmd_ok &&
    (omc_pkg::omc_cmd_t'(cmd_code) == omc_pkg::OMC_CMD_DBGREG);

  // Command filter by current mode.
  always_comb begin
    cmd_ok = 1'b0;
    case (omc_pkg::omc_cmd_t'(cmd_code))
      omc_pkg::OMC_CMD_MEM, omc_pkg::OMC_CMD_DBGREG:
        cmd_ok = (state == omc_pkg::OMC_RUN) ||
                 (state == omc_pkg::OMC_BKG);
      omc_pkg::OMC_CMD_MEMSTAT:
        cmd_ok = 1'b1;
      omc_pkg::OMC_CMD_HALT:
        cmd_ok = !in_stop || debug_enable;
      omc_pkg::OMC_CMD_CPUREG, omc_pkg::OMC_CMD_TRACE,
      omc_pkg::OMC_CMD_GO:
        cmd_ok = (state == omc_pkg::OMC_BKG);
      default:
        cmd_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      omc_pkg::OMC_RUN: begin
        if (halt_cmd || bkg_instr || debug_ctl_breakpoint || dbg_breakpoint)
          next_state = omc_pkg::OMC_BKG;
        else if (wait_instr)
          next_state = omc_pkg::OMC_WAIT;
        else if (stop_instr && stop_ok) begin
          if (debug_enable)
            next_state = omc_pkg::OMC_STOP3;
          else if (ctrl[`OMC_CTRL_LV_DET] && ctrl[`OMC_CTRL_LV_STOP])
            next_state = omc_pkg::OMC_STOP3;
          else if (ctrl[`OMC_CTRL_PART_PD])
            next_state = omc_pkg::OMC_STOP2;
          else
            next_state = omc_pkg::OMC_STOP3;
        end
      end
      omc_pkg::OMC_BKG: begin
        if (go_cmd)
          next_state = omc_pkg::OMC_RUN;
      end
      omc_pkg::OMC_WAIT: begin
        if (halt_cmd)
          next_state = omc_pkg::OMC_BKG;
        else if (irq_request)
          next_state = omc_pkg::OMC_RUN;
      end
      omc_pkg::OMC_STOP3: begin
        if (halt_cmd && debug_enable)
          next_state = omc_pkg::OMC_BKG;
        else if (wake_any)
          next_state = omc_pkg::OMC_RUN;
      end
      omc_pkg::OMC_STOP2: begin
        if (halt_cmd && debug_enable)
          next_state = omc_pkg::OMC_BKG;
      end
      default:
        next_state = omc_pkg::OMC_RUN;
    endcase
  end

  // Mode state; the reset pin restarts the boot sequence from any mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= omc_pkg::OMC_BKG;
      boot_pending <= 1'b1;
    end else if (!rst_sync[1]) begin
      state <= omc_pkg::OMC_BKG;
      boot_pending <= 1'b1;
    end else if (boot_pending) begin
      boot_pending <= 1'b0;
      state <= ms_sync[1] ? omc_pkg::OMC_RUN
                          : omc_pkg::OMC_BKG;
    end else if (!(stop_instr && !stop_ok && state == omc_pkg::OMC_RUN)) begin
      state <= next_state;
    end else begin
      state <= omc_pkg::OMC_BKG;
      boot_pending <= 1'b1;
    end
  end

  // Illegal-opcode reset pulse when STOP runs with stop modes disabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      illegal_op_reset <= 1'b0;
    else
      illegal_op_reset <= !boot_pending && rst_sync[1] && stop_instr &&
                          !stop_ok &&
                          state == omc_pkg::OMC_RUN;
  end

  // One-cycle request to clear the interrupt mask on wait entry.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      int_mask_clear <= 1'b0;
    else
      int_mask_clear <= !boot_pending && rst_sync[1] &&
                        state == omc_pkg::OMC_RUN &&
                        next_state == omc_pkg::OMC_WAIT;
  end

  // Reset vector fetch when the boot sample selects run mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      vector_fetch <= 1'b0;
    else
      vector_fetch <= boot_pending && rst_sync[1] && ms_sync[1];
  end

  // Vector address; it keeps its value between fetches.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      vector_addr <= 16'h0000;
    else if (boot_pending && rst_sync[1] && ms_sync[1])
      vector_addr <= `OMC_RESET_VECTOR;
  end

  // Interrupt vector fetch when wait or stop3 ends on an interrupt.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      int_vector_fetch <= 1'b0;
    else
      int_vector_fetch <= !boot_pending && rst_sync[1] &&
        (state == omc_pkg::OMC_WAIT || state == omc_pkg::OMC_STOP3) &&
        next_state == omc_pkg::OMC_RUN;
  end

  // Command taken in the current mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_accept <= 1'b0;
    else
      cmd_accept <= cmd_valid && cmd_ok;
  end

  // Command refused in the current mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_refuse <= 1'b0;
    else
      cmd_refuse <= cmd_valid && !cmd_ok;
  end

  // Status commands report the stop/wait error outside run and background.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_stopwait_err <= 1'b0;
    else
      cmd_stopwait_err <= cmd_valid && (omc_pkg::omc_cmd_t'(cmd_code) ==
        omc_pkg::OMC_CMD_MEMSTAT) && state != omc_pkg::OMC_RUN &&
        state != omc_pkg::OMC_BKG;
  end

  // Debug enable bit; the CPU bus cannot write it, but reads it in the status word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      debug_enable <= 1'b0;
    else if (dbg_reg_hit && cmd_dbg_write)
      debug_enable <= cmd_wdata[`OMC_DSC_DEBUG_EN];
  end

  // Read-back returns the bit as it stood before a write in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cmd_rdata <= 32'h0000_0000;
    else if (dbg_reg_hit)
      cmd_rdata <= {31'h0, debug_enable};
  end

  // The CPU clock runs only in run and background modes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cpu_clk_en <= 1'b0;
    else
      cpu_clk_en <= state == omc_pkg::OMC_RUN ||
                    state == omc_pkg::OMC_BKG;
  end

  // User fetches only in run mode, never while a boot is pending.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cpu_fetch_en <= 1'b0;
    else
      cpu_fetch_en <= state == omc_pkg::OMC_RUN && !boot_pending;
  end

  // System clocks stop in stop modes unless reference clocks are kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      sys_clk_en <= 1'b1;
    else
      sys_clk_en <= !in_stop || ctrl[`OMC_CTRL_REFKEEP];
  end

  // Debug logic keeps its clock in stop while debug is enabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      debug_clk_en <= 1'b1;
    else
      debug_clk_en <= !in_stop || debug_enable;
  end

  // Full regulation outside stop, or in stop with debug or both low-voltage enables set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      regulator_full <= 1'b1;
    else
      regulator_full <= !in_stop || debug_enable ||
        (ctrl[`OMC_CTRL_LV_DET] &&
         ctrl[`OMC_CTRL_LV_STOP]);
  end

  // Registers, RAM and pin levels are held in stop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state_hold <= 1'b0;
    else
      state_hold <= in_stop;
  end

  // Visible mode code, one cycle behind the state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mode <= 3'h0;
    else
      mode <= state;
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end

  // Control word is written in the data phase that follows its address.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl <= `OMC_CTRL_RESET;
    else if (ph_valid && ph_write && ph_addr == `OMC_ADDR_CTRL)
      ctrl <= {27'h0, hwdata[4:0]};
  end

  // Read data is loaded at the address phase and stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        `OMC_ADDR_CTRL: hrdata <= ctrl;
        `OMC_ADDR_STATUS: hrdata <= {28'h0, debug_enable, state};
        `OMC_ADDR_DBGSC: hrdata <= 32'h0000_0000;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : omc_top

// ==== omc_props.sv ====
module omc_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic wait_instr,
  input wire logic irq_request,
  input wire logic cmd_accept,
  input wire logic cmd_refuse,
  input wire logic cmd_stopwait_err,
  input wire logic cpu_clk_en,
  input wire logic cpu_fetch_en,
  input wire logic sys_clk_en,
  input wire logic regulator_full,
  input wire logic state_hold,
  input wire logic int_mask_clear,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic int_vector_fetch,
  input wire logic [2:0] mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  cmd_answer_a: assert property (cmd_valid |=>
    cmd_accept != cmd_refuse) else $error("command not answered once");
  run_refuse_a: assert property (cmd_valid && mode == 3'h0 &&
    cmd_code inside {4'h4, 4'h5, 4'h6} |=> cmd_refuse)
    else $error("halt-only command taken while running");
  wait_refuse_a: assert property (cmd_valid && mode == 3'h2 &&
    !(cmd_code inside {4'h1, 4'h3}) |=> cmd_refuse)
    else $error("command taken in wait");
  stat_err_a: assert property (cmd_valid && cmd_code == 4'h1 &&
    mode inside {3'h2, 3'h3, 3'h4} |=> cmd_accept && cmd_stopwait_err)
    else $error("status command lacks stop or wait error");
  bkg_nofetch_a: assert property (mode == 3'h1 |-> !cpu_fetch_en)
    else $error("fetch while suspended");
  wait_clocks_a: assert property (mode == 3'h2 |->
    !cpu_clk_en && sys_clk_en && regulator_full)
    else $error("wrong clocks in wait");
  wait_ccr_a: assert property (wait_instr && mode == 3'h0 |->
    ##[1:3] int_mask_clear) else $error("mask bit not cleared");
  irq_wake_a: assert property (mode == 3'h2 && irq_request &&
    !cmd_valid |-> ##[1:4] int_vector_fetch)
    else $error("interrupt did not end wait");
  stop_hold_a: assert property (mode == 3'h3 |->
    state_hold && !cpu_clk_en) else $error("state not held in stop");
  reset_vec_a: assert property (vector_fetch |->
    vector_addr == 16'hfffe) else $error("wrong reset vector");
  stop_mem_a: assert property (cmd_valid && mode inside {3'h3, 3'h4} &&
    cmd_code == 4'h0 |=> cmd_refuse) else $error("memory access in stop");
endmodule : omc_props

// ==== omc_host.sv ====
module omc_host (
  input wire logic hclk,
  input wire logic cmd_accept,
  input wire logic cmd_refuse,
  input wire logic cmd_stopwait_err,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic cmd_dbg_write,
  output logic [31:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h7;
    cmd_dbg_write = 1'b0;
    cmd_wdata = 32'h0;
  end
  // Idle fields carry junk so a stale command is never mistaken for a new one.
  task automatic send(input logic [3:0] c, input logic w,
      input logic [31:0] d, output logic [2:0] r);
    @(posedge hclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_dbg_write <= w;
    cmd_wdata <= d;
    @(posedge hclk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_dbg_write <= 1'b0;
    cmd_wdata <= ~d;
    #1;
    r = {cmd_accept, cmd_refuse, cmd_stopwait_err};
  endtask : send
endmodule : omc_host

// ==== omc_tb.sv ====
`include "omc_map.svh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  err_total++; $display("unexpected %s exp %0h got %0h", nm, e, s); end end
`define WT(x) n = 0; do begin @(posedge hclk); #1; n++; end \
  while (!(x) && n < 40);
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cmd_wdata, cmd_rdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, mode, r3;
  logic mode_select_pin = 1'b0, bkg_instr = 1'b0;
  logic debug_ctl_breakpoint = 1'b0;
  logic dbg_breakpoint = 1'b0, wait_instr = 1'b0, stop_instr = 1'b0;
  logic irq_request = 1'b0, reset_pin_n = 1'b1, hreadyout, hresp;
  logic [7:0] wake_src = 8'h0;
  logic [3:0] cmd_code;
  logic [15:0] vector_addr;
  logic cmd_valid, cmd_dbg_write, cmd_accept, cmd_refuse, cmd_stopwait_err;
  logic cpu_clk_en, cpu_fetch_en, sys_clk_en, debug_clk_en, regulator_full;
  logic state_hold, int_mask_clear, illegal_op_reset, vector_fetch;
  logic int_vector_fetch;
  logic [31:0] r;
  int err_total = 0, cmp_count = 0, n, k, cyc = 0;
  // Row: command code, accepted, mode two cycles on (7 means any).
  localparam logic [7:0] ROWS [13] = '{8'h09, 8'h19, 8'h29, 8'h49, 8'h5f,
    8'h39, 8'h68, 8'h40, 8'h50, 8'h60, 8'h08, 8'h18, 8'h28};
  localparam logic [31:0] SC [3] = '{32'h9, 32'h1, 32'hf};
  localparam logic [2:0] SM [3] = '{3'h4, 3'h3, 3'h3};
  always #4 hclk = ~hclk;
  omc_top dut_u (.hready(hreadyout), .*);
  omc_host host_u (.*);
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask : ahb
  task automatic cmd(input logic [3:0] c, input logic w,
      input logic [31:0] d, input logic [2:0] e);
    host_u.send(c, w, d, r3);
    `CHK("command answer", e, r3)
  endtask : cmd
  task automatic wm(input logic [2:0] m);
    `WT(mode === m)
    `CHK("mode", m, mode)
  endtask : wm
  task automatic pl(input int s);
    @(posedge hclk);
    case (s)
      0: wait_instr <= 1'b1;
      1: stop_instr <= 1'b1;
      2: irq_request <= 1'b1;
      3: bkg_instr <= 1'b1;
      4: debug_ctl_breakpoint <= 1'b1;
      default: dbg_breakpoint <= 1'b1;
    endcase
    @(posedge hclk);
    {wait_instr, stop_instr, irq_request} <= 3'h0;
    {bkg_instr, debug_ctl_breakpoint, dbg_breakpoint} <= 3'h0;
  endtask : pl
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    wm(3'h1);
    ahb(1'b0, `OMC_ADDR_CTRL, 32'h0, r);
    `CHK("ctrl", `OMC_CTRL_RESET, r)
    `CHK("response", 1'b0, hresp)
    ahb(1'b0, `OMC_ADDR_STATUS, 32'h0, r);
    `CHK("status", 32'h1, r)
    ahb(1'b0, `OMC_ADDR_DBGSC, 32'h0, r);
    `CHK("debug word", 32'h0, r)
    ahb(1'b0, 32'hc, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    for (k = 0; k < 13; k++) begin
      cmd(ROWS[k][7:4], 1'b0, 32'h0, {ROWS[k][3], !ROWS[k][3], 1'b0});
      @(posedge hclk);
      #1;
      if (ROWS[k][2:0] != 3'h7) `CHK("mode", ROWS[k][2:0], mode)
    end
    mode_select_pin <= 1'b1;
    for (k = 3; k < 6; k++) begin
      pl(k);
      wm(3'h1);
      cmd(4'h6, 1'b0, 32'h0, 3'h4);
      wm(3'h0);
    end
    pl(0);
    wm(3'h2);
    cmd(4'h0, 1'b0, 32'h0, 3'h2);
    cmd(4'h1, 1'b0, 32'h0, 3'h5);
    pl(2);
    wm(3'h0);
    pl(0);
    wm(3'h2);
    cmd(4'h3, 1'b0, 32'h0, 3'h4);
    wm(3'h1);
    cmd(4'h6, 1'b0, 32'h0, 3'h4);
    wm(3'h0);
    pl(1);
    #1;
    `CHK("illegal op", 1'b1, illegal_op_reset)
    `WT(vector_fetch)
    `CHK("vector fetch", 1'b1, vector_fetch)
    wm(3'h0);
    for (k = 0; k < 3; k++) begin
      ahb(1'b1, `OMC_ADDR_CTRL, SC[k], r);
      ahb(1'b0, `OMC_ADDR_CTRL, 32'h0, r);
      `CHK("ctrl", SC[k], r)
      pl(1);
      wm(SM[k]);
      cmd(4'h0, 1'b0, 32'h0, 3'h2);
      cmd(4'h1, 1'b0, 32'h0, 3'h5);
      cmd(4'h3, 1'b0, 32'h0, 3'h2);
      @(posedge hclk);
      if (k == 0) reset_pin_n <= 1'b0;
      else wake_src <= 8'h01 << k;
      repeat (4) @(posedge hclk);
      reset_pin_n <= 1'b1;
      wake_src <= 8'h0;
      wm(3'h0);
    end
    cmd(4'h2, 1'b1, 32'h1, 3'h4);
    cmd(4'h2, 1'b0, 32'h0, 3'h4);
    `CHK("debug enable", 32'h1, cmd_rdata)
    ahb(1'b1, `OMC_ADDR_CTRL, 32'h9, r);
    pl(1);
    wm(3'h3);
    `CHK("debug clock", 1'b1, debug_clk_en)
    `CHK("regulator", 1'b1, regulator_full)
    cmd(4'h3, 1'b0, 32'h0, 3'h4);
    wm(3'h1);
    ahb(1'b0, `OMC_ADDR_STATUS, 32'h0, r);
    `CHK("status", 32'h9, r)
    report_and_stop();
  end
endmodule : testbench
bind omc_top omc_props props_u (.*);
